// *** src/irp_pkg.sv ***
// constants and types shared by the register port with peak hold
package irp_pkg;

  // register pointer of the highest-conversion register
  localparam logic [7:0] PTR_HIGHEST = 8'h07;
  // value of the highest-conversion register after reset
  localparam logic [11:0] HIGHEST_RST = 12'h000;
  // value of the register pointer after reset
  localparam logic [7:0] PTR_RST = 8'h00;
  // reserved upper nibble of a 16-bit register word
  localparam logic [3:0] RSVD_ZERO = 4'h0;
  // own 7-bit target address
  localparam logic [6:0] OWN_ADDR = 7'h54;
  // upper five bits of the high-speed entry code 00001xxx
  localparam logic [4:0] HS_PREFIX = 5'h01;

  // rising-edge counts within one byte slot
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_WAIT
  } irp_state_t;

endpackage

// *** src/irp_line_sync.sv ***
// two-flop synchronisers and edge, start and stop detection for the bus lines
`timescale 1ns/1ps
module irp_line_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);

  logic scl_m_r;
  logic scl_s_r;
  logic scl_d_r;
  logic sda_m_r;
  logic sda_s_r;
  logic sda_d_r;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  assign sda_s = sda_s_r;
  assign scl_rise = clk_en && scl_s_r && !scl_d_r;
  assign scl_fall = clk_en && !scl_s_r && scl_d_r;
  // data moving while the clock stays high marks start or stop
  assign start_det = clk_en && scl_s_r && scl_d_r && !sda_s_r && sda_d_r;
  assign stop_det = clk_en && scl_s_r && scl_d_r && sda_s_r && !sda_d_r;

endmodule

// *** src/irp_top.sv ***
// two-wire target port with register pointer and highest-conversion peak hold
`timescale 1ns/1ps
module irp_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  input wire logic [15:0] ext_rdata,
  output logic [7:0] pointer,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic [11:0] highest_value,
  output logic hs_mode
);

  logic rst_q1_r;
  logic rst_sync_n;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  irp_pkg::irp_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic ack_r;
  logic rw_r;
  logic lo_r;
  logic [7:0] hi_r;
  logic [15:0] word_r;
  logic [7:0] pointer_r;
  logic sda_oe_r;
  logic sda_o_r;
  logic [11:0] highest_r;
  logic hs_mode_r;
  logic reg_wr_r;
  logic [15:0] reg_wdata_r;
  logic busy;
  logic [7:0] rx_byte;
  logic rx_last;
  logic hs_code;
  logic addr_match;
  logic [15:0] rd_word;
  logic tx_load;
  logic [7:0] tx_byte;
  logic wr_commit;
  logic [15:0] wr_word;
  logic wr_hit;

  // reset is applied asynchronously at once but is released through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_q1_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_q1_r <= 1'b1;
      rst_sync_n <= rst_q1_r;
    end
  end

  // oversampled lines
  // the block clock samples both lines, so every bus rate takes the same path
  irp_line_sync u_sync (
    .clk(clk),
    .rst_n(rst_sync_n),
    .clk_en(clk_en),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  assign busy = (state_r != irp_pkg::ST_IDLE) && (state_r != irp_pkg::ST_WAIT);
  assign rx_byte = {shift_r[6:0], sda_s};
  assign rx_last = scl_rise && (bit_cnt_r == irp_pkg::BIT_LAST);
  assign hs_code = (rx_byte[7:3] == irp_pkg::HS_PREFIX);
  assign addr_match = (rx_byte[7:1] == irp_pkg::OWN_ADDR);

  assign rd_word = (pointer_r == irp_pkg::PTR_HIGHEST) ?
    {irp_pkg::RSVD_ZERO, highest_r} : ext_rdata;

  assign tx_load = scl_fall && (bit_cnt_r == irp_pkg::BIT_END) &&
    (((state_r == irp_pkg::ST_ADDR) && ack_r && rw_r) || (state_r == irp_pkg::ST_RDATA));
  assign tx_byte = ((state_r == irp_pkg::ST_RDATA) && lo_r) ? word_r[7:0] : rd_word[15:8];

  assign wr_commit = rx_last && (state_r == irp_pkg::ST_WDATA) && lo_r;
  assign wr_word = {hi_r, rx_byte};
  assign wr_hit = wr_commit && (pointer_r == irp_pkg::PTR_HIGHEST);

  // transfer sequencing
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      state_r <= irp_pkg::ST_IDLE;
    else if (clk_en)
    begin
      if (stop_det)
        state_r <= irp_pkg::ST_IDLE;
      else if (start_det)
        state_r <= irp_pkg::ST_ADDR;
      else if (scl_rise && (state_r == irp_pkg::ST_RDATA) &&
               (bit_cnt_r == irp_pkg::BIT_ACK) && sda_s)
        state_r <= irp_pkg::ST_WAIT;
      else if (scl_fall && (bit_cnt_r == irp_pkg::BIT_END))
      begin
        case (state_r)
          irp_pkg::ST_ADDR:
            state_r <= !ack_r ? irp_pkg::ST_WAIT :
              (rw_r ? irp_pkg::ST_RDATA : irp_pkg::ST_PTR);
          irp_pkg::ST_PTR:
            state_r <= irp_pkg::ST_WDATA;
          default:
            state_r <= state_r;
        endcase
      end
    end
  end

  // rising edges counted per byte, nine with the acknowledge slot
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      bit_cnt_r <= irp_pkg::BIT_ZERO;
    else if (clk_en)
    begin
      if (start_det || stop_det || !busy)
        bit_cnt_r <= irp_pkg::BIT_ZERO;
      else if (scl_rise)
        bit_cnt_r <= bit_cnt_r + 4'h1;
      else if (scl_fall && (bit_cnt_r == irp_pkg::BIT_END))
        bit_cnt_r <= irp_pkg::BIT_ZERO;
    end
  end

  // one shifter serves receive and transmit
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      shift_r <= 8'h00;
    else if (clk_en)
    begin
      if (tx_load)
        shift_r <= {tx_byte[6:0], 1'b0};
      else if (scl_fall && (state_r == irp_pkg::ST_RDATA) &&
               (bit_cnt_r != irp_pkg::BIT_ZERO) && (bit_cnt_r < irp_pkg::BIT_ACK))
        shift_r <= {shift_r[6:0], 1'b0};
      else if (scl_rise && busy && (state_r != irp_pkg::ST_RDATA) &&
               (bit_cnt_r < irp_pkg::BIT_ACK))
        shift_r <= rx_byte;
    end
  end

  // acknowledge decision and direction, taken at the eighth rising edge
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ack_r <= 1'b0;
      rw_r <= 1'b0;
    end
    else if (clk_en && rx_last)
    begin
      if (state_r == irp_pkg::ST_ADDR)
      begin
        ack_r <= addr_match && !hs_code;
        rw_r <= sda_s;
      end
      else if ((state_r == irp_pkg::ST_PTR) || (state_r == irp_pkg::ST_WDATA))
        ack_r <= 1'b1;
    end
  end

  // byte half tracking for writes and reads
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      lo_r <= 1'b0;
      hi_r <= 8'h00;
    end
    else if (clk_en)
    begin
      if (start_det)
        lo_r <= 1'b0;
      else if (rx_last && (state_r == irp_pkg::ST_PTR))
        lo_r <= 1'b0;
      else if (rx_last && (state_r == irp_pkg::ST_WDATA))
      begin
        lo_r <= !lo_r;
        if (!lo_r)
          hi_r <= rx_byte;
      end
      else if (scl_rise && (state_r == irp_pkg::ST_RDATA) &&
               (bit_cnt_r == irp_pkg::BIT_ACK) && !sda_s)
        lo_r <= !lo_r;
    end
  end

  // word snapshot keeps both halves of one read consistent
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      word_r <= 16'h0000;
    else if (clk_en && tx_load && !((state_r == irp_pkg::ST_RDATA) && lo_r))
      word_r <= rd_word;
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      pointer_r <= irp_pkg::PTR_RST;
    else if (clk_en && rx_last && (state_r == irp_pkg::ST_PTR))
      pointer_r <= rx_byte;
  end

  // data line drive, changed while the clock is low and released at start or stop
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      sda_oe_r <= 1'b0;
    else if (clk_en)
    begin
      if (start_det || stop_det)
        sda_oe_r <= 1'b0;
      else if (tx_load)
        sda_oe_r <= !tx_byte[7];
      else if (scl_fall && busy)
      begin
        if (bit_cnt_r == irp_pkg::BIT_ACK)
          sda_oe_r <= (state_r != irp_pkg::ST_RDATA) && ack_r;
        else if (bit_cnt_r == irp_pkg::BIT_END)
          sda_oe_r <= 1'b0;
        else if ((state_r == irp_pkg::ST_RDATA) && (bit_cnt_r != irp_pkg::BIT_ZERO))
          sda_oe_r <= !shift_r[7];
      end
    end
  end

  // open drain: the driven level is always low
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      sda_o_r <= 1'b0;
    else if (clk_en)
      sda_o_r <= 1'b0;
  end

  // peak hold; a conversion lost while clk_en is low is not recovered
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      highest_r <= irp_pkg::HIGHEST_RST;
    else if (clk_en)
    begin
      if (wr_hit)
        highest_r <= wr_word[11:0];
      else if (conv_done && (conv_result > highest_r))
        highest_r <= conv_result;
    end
  end

  // high-speed mode flag
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      hs_mode_r <= 1'b0;
    else if (clk_en)
    begin
      if (stop_det)
        hs_mode_r <= 1'b0;
      else if (rx_last && (state_r == irp_pkg::ST_ADDR) && hs_code)
        hs_mode_r <= 1'b1;
    end
  end

  // full words go to the rest of the register map as one-cycle strobes
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      reg_wr_r <= 1'b0;
      reg_wdata_r <= 16'h0000;
    end
    else if (clk_en)
    begin
      reg_wr_r <= wr_commit;
      if (wr_commit)
        reg_wdata_r <= wr_word;
    end
  end

  assign sda_o = sda_o_r;
  assign sda_oe = sda_oe_r;
  assign pointer = pointer_r;
  assign reg_wr = reg_wr_r;
  assign reg_wdata = reg_wdata_r;
  assign highest_value = highest_r;
  assign hs_mode = hs_mode_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_n);

  chk_peak_read_map: assert property (clk_en && tx_load && !lo_r && (pointer_r == 8'h07) |=> word_r[11:0] == $past(highest_r))
    else $error("peak register not served at its pointer");
  chk_rsvd_read_zero: assert property (clk_en && tx_load && (pointer_r == 8'h07) && !lo_r |=> word_r[15:12] == 4'h0)
    else $error("reserved bits not zero on read");
  chk_peak_greater: assert property (clk_en && conv_done && !wr_hit && (conv_result > highest_r) |=> highest_r == $past(conv_result))
    else $error("greater result not stored");
  chk_peak_kept: assert property (clk_en && conv_done && !wr_hit && (conv_result <= highest_r) |=> $stable(highest_r))
    else $error("peak changed by smaller result");
  chk_peak_clear: assert property (clk_en && wr_hit && (wr_word[11:0] == 12'h000) |=> highest_r == 12'h000)
    else $error("peak not cleared by write");
  chk_auto_update: assert property (clk_en && (state_r == irp_pkg::ST_IDLE) && conv_done && (conv_result > highest_r) |=> highest_r == $past(conv_result))
    else $error("peak not updated without bus");
  chk_drive_low: assert property (sda_oe_r |-> sda_o_r == 1'b0)
    else $error("data line driven high");
  chk_start_any_speed: assert property (clk_en && start_det && hs_mode_r |=> state_r == irp_pkg::ST_ADDR && bit_cnt_r == 4'h0)
    else $error("start handled differently in high-speed");
  chk_start_addr: assert property (clk_en && start_det && (state_r == irp_pkg::ST_IDLE) |=> state_r == irp_pkg::ST_ADDR ##1 !sda_oe_r)
    else $error("start not detected");
  chk_restart_speed: assert property (clk_en && start_det |=> hs_mode_r == $past(hs_mode_r))
    else $error("speed changed at repeated start");
  chk_stop_idle: assert property (clk_en && stop_det |=> state_r == irp_pkg::ST_IDLE && !sda_oe_r)
    else $error("stop did not idle the port");
  chk_addr_ack: assert property (clk_en && scl_fall && (state_r == irp_pkg::ST_ADDR) && (bit_cnt_r == 4'h8) |=> sda_oe_r == $past(ack_r))
    else $error("address acknowledge wrong");
  chk_ptr_load: assert property (clk_en && rx_last && (state_r == irp_pkg::ST_PTR) |=> pointer_r == $past(rx_byte) && ack_r)
    else $error("pointer not loaded");
  chk_write_ack: assert property (clk_en && scl_fall && (bit_cnt_r == 4'h8) && ((state_r == irp_pkg::ST_PTR) || (state_r == irp_pkg::ST_WDATA)) |=> sda_oe_r)
    else $error("write byte not acknowledged");
  chk_word_write: assert property (clk_en && wr_commit |=> reg_wr_r && reg_wdata_r == $past(wr_word) ##1 !reg_wr_r)
    else $error("word write not committed once");
  chk_read_upper: assert property (clk_en && tx_load && (state_r == irp_pkg::ST_ADDR) |=> state_r == irp_pkg::ST_RDATA && sda_oe_r == !$past(rd_word[15]))
    else $error("read did not start with upper byte");
  chk_nack_release: assert property (state_r == irp_pkg::ST_WAIT |-> !sda_oe_r)
    else $error("line driven after not-acknowledge");
  chk_lower_next: assert property (clk_en && scl_rise && (state_r == irp_pkg::ST_RDATA) && (bit_cnt_r == 4'h8) && !sda_s && !lo_r |=> lo_r && state_r == irp_pkg::ST_RDATA)
    else $error("lower byte not selected");
  chk_upper_wrap: assert property (clk_en && scl_rise && (state_r == irp_pkg::ST_RDATA) && (bit_cnt_r == 4'h8) && !sda_s && lo_r |=> !lo_r && state_r == irp_pkg::ST_RDATA)
    else $error("read did not wrap to upper byte");
  chk_hs_nack: assert property (clk_en && rx_last && (state_r == irp_pkg::ST_ADDR) && hs_code |=> hs_mode_r && !ack_r)
    else $error("high-speed code not refused");
  chk_hs_stop: assert property (clk_en && stop_det |=> !hs_mode_r)
    else $error("high-speed kept after stop");
  chk_bus_wins: assert property (clk_en && wr_hit && conv_done |=> highest_r == $past(wr_word[11:0]))
    else $error("conversion beat bus write");

  cov_peak_write: cover property (clk_en && wr_hit);
  cov_read_wrap: cover property (clk_en && tx_load && (state_r == irp_pkg::ST_RDATA) && !lo_r);
  cov_hs_entry: cover property (clk_en && $rose(hs_mode_r));
  cov_addr_nack: cover property (clk_en && scl_fall && (state_r == irp_pkg::ST_ADDR) && (bit_cnt_r == 4'h8) && !ack_r);

endmodule

// *** test/irp_master_model.sv ***
// behavioural two-wire bus controller that drives the target port
`timescale 1ns/1ps
module irp_master_model (
  output logic scl_o,
  output logic sda_pull,
  input wire logic sda_i
);
  // clock stands high and data is released outside frames
  initial
  begin
    scl_o = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic start();
    #100 sda_pull = 1'b1;
    #50 scl_o = 1'b0;
  endtask

  task automatic rstart();
    #50 sda_pull = 1'b0;
    #50 scl_o = 1'b1;
    #50 sda_pull = 1'b1;
    #50 scl_o = 1'b0;
  endtask

  task automatic stop();
    #50 sda_pull = 1'b1;
    #50 scl_o = 1'b1;
    #50 sda_pull = 1'b0;
    #100;
  endtask

  // data changes mid-low so the target's hold time is respected
  task automatic bit_xfer(input logic b, output logic r);
    #50 sda_pull = ~b;
    #50 scl_o = 1'b1;
    #50 r = sda_i;
    #50 scl_o = 1'b0;
  endtask

  // eight bits msb first, then line released for acknowledge
  task automatic wbyte(input logic [7:0] b, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], r);
    bit_xfer(1'b1, r);
    acked = ~r;
  endtask

  // not-acknowledge after the last wanted byte
  task automatic rbyte(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(1'b1, d[i]);
    bit_xfer(~ack, r);
  endtask
endmodule

// *** test/irp_top_tb.sv ***
// self-checking bench for the register port with peak hold
`timescale 1ns/1ps
module irp_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic conv_done = 1'b0;
  logic [11:0] conv_result = 12'h000;
  logic [15:0] ext_rdata = 16'h0000;
  logic scl_w;
  logic m_pull;
  logic sda_o;
  logic sda_oe;
  logic [7:0] pointer;
  logic reg_wr;
  logic [15:0] reg_wdata;
  logic [11:0] highest_value;
  logic hs_mode;
  int err_count = 0;
  int n_checks = 0;
  int wr_cnt = 0;
  logic a;
  logic [7:0] d;
  logic clk_en = 1'b1;
  logic ramp = 1'b0;
  // open drain with pull-up: low wins
  wire sda_w = (sda_oe ? sda_o : 1'b1) & ~m_pull;

  always #12.5 clk = ~clk;

  irp_top dut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .scl_i(scl_w), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .conv_done(conv_done), .conv_result(conv_result),
    .ext_rdata(ext_rdata), .pointer(pointer), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .highest_value(highest_value), .hs_mode(hs_mode)
  );

  irp_master_model m (
    .scl_o(scl_w), .sda_pull(m_pull), .sda_i(sda_w)
  );

  always @(posedge clk)
    if (reg_wr === 1'b1)
      wr_cnt <= wr_cnt + 1;

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // full write: pointer then n data bytes, then stop
  task automatic wr_bytes(input logic [7:0] ptr, input logic [15:0] w, input int n);
    m.start();
    m.wbyte(8'hA8, a);
    chk("addr ack", {15'h0, a}, 16'h0001);
    m.wbyte(ptr, a);
    chk("ptr ack", {15'h0, a}, 16'h0001);
    for (int i = 0; i < n; i++)
    begin
      m.wbyte(i == 0 ? w[15:8] : w[7:0], a);
      chk("data ack", {15'h0, a}, 16'h0001);
    end
    m.stop();
  endtask

  task automatic conv(input logic [11:0] v);
    @(posedge clk);
    conv_done <= 1'b1;
    conv_result <= v;
    @(posedge clk);
    conv_done <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    chk("pointer", {8'h00, pointer}, 16'h0000);
    chk("highest", {4'h0, highest_value}, 16'h0000);
    chk("hs", {15'h0, hs_mode}, 16'h0000);
    chk("oe", {15'h0, sda_oe}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_other_addr();
    m.start();
    m.wbyte(8'hAA, a);
    chk("nack other", {15'h0, a}, 16'h0000);
    m.stop();
    $display("test other address done");
  endtask

  task automatic t_write();
    wr_bytes(8'h07, 16'h0ABC, 2);
    chk("pointer", {8'h00, pointer}, 16'h0007);
    chk("wdata", reg_wdata, 16'h0ABC);
    chk("wr count", wr_cnt[15:0], 16'h0001);
    chk("highest", {4'h0, highest_value}, 16'h0ABC);
    $display("test write done");
  endtask

  task automatic t_conv();
    // a conversion pulse while the block is frozen is lost
    @(posedge clk);
    clk_en <= 1'b0;
    conv(12'hFFE);
    chk("frozen", {4'h0, highest_value}, 16'h0ABC);
    @(posedge clk);
    clk_en <= 1'b1;
    conv(12'hABD);
    chk("bigger", {4'h0, highest_value}, 16'h0ABD);
    conv(12'h123);
    chk("smaller", {4'h0, highest_value}, 16'h0ABD);
    conv(12'hABD);
    chk("equal", {4'h0, highest_value}, 16'h0ABD);
    $display("test conversion done");
  endtask

  task automatic t_read();
    m.start();
    m.wbyte(8'hA9, a);
    chk("rd ack", {15'h0, a}, 16'h0001);
    m.rbyte(d, 1'b1);
    chk("upper", {8'h00, d}, 16'h000A);
    m.rbyte(d, 1'b1);
    chk("lower", {8'h00, d}, 16'h00BD);
    m.rbyte(d, 1'b0);
    chk("upper again", {8'h00, d}, 16'h000A);
    chk("released", {15'h0, sda_oe}, 16'h0000);
    chk("drive low", {15'h0, sda_o}, 16'h0000);
    m.stop();
    $display("test read done");
  endtask

  task automatic t_single();
    wr_bytes(8'h07, 16'h0500, 1);
    chk("no commit", wr_cnt[15:0], 16'h0001);
    chk("kept", {4'h0, highest_value}, 16'h0ABD);
    // rising conversions every cycle, so one lands on the word commit
    ramp = 1'b1;
    fork
      begin
        wr_bytes(8'h07, 16'h0FFF, 2);
        ramp = 1'b0;
      end
      while (ramp)
      begin
        @(posedge clk);
        conv_done <= ramp;
        conv_result <= conv_result + 12'h001;
      end
    join
    chk("bus wins", {4'h0, highest_value}, 16'h0FFF);
    wr_bytes(8'h07, 16'h0000, 2);
    chk("cleared", {4'h0, highest_value}, 16'h0000);
    conv(12'h001);
    chk("new peak", {4'h0, highest_value}, 16'h0001);
    $display("test single and clear done");
  endtask

  task automatic t_restart_read();
    @(posedge clk);
    ext_rdata <= 16'h1234;
    m.start();
    m.wbyte(8'hA8, a);
    m.wbyte(8'h03, a);
    m.rstart();
    m.wbyte(8'hA9, a);
    chk("rs ack", {15'h0, a}, 16'h0001);
    m.rbyte(d, 1'b1);
    chk("ext upper", {8'h00, d}, 16'h0012);
    m.rbyte(d, 1'b0);
    chk("ext lower", {8'h00, d}, 16'h0034);
    m.stop();
    chk("pointer", {8'h00, pointer}, 16'h0003);
    $display("test restart read done");
  endtask

  task automatic t_hs();
    m.start();
    m.wbyte(8'h0B, a);
    chk("hs nack", {15'h0, a}, 16'h0000);
    chk("hs on", {15'h0, hs_mode}, 16'h0001);
    m.rstart();
    m.wbyte(8'hA8, a);
    chk("hs addr ack", {15'h0, a}, 16'h0001);
    chk("hs kept", {15'h0, hs_mode}, 16'h0001);
    m.stop();
    repeat (8) @(posedge clk);
    chk("hs off", {15'h0, hs_mode}, 16'h0000);
    $display("test high speed done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    #7;
    t_reset();
    t_other_addr();
    t_write();
    t_conv();
    t_read();
    t_single();
    t_restart_read();
    t_hs();
    final_report();
  end

  // whole run is near 52 us of bus traffic
  initial
  begin
    #600000;
    err_count++;
    $display("watchdog expired");
    final_report();
  end
endmodule
